// ### logic/auto_torque_control_regs.sv
/*
  Auto-torque register bank with load-adaptive current loop and learning
  sequencer. Registers are reached over a simple byte register port that
  the serial control front end drives.
  Assumes all inputs synchronous to clock_i; half_cycle_i pulses once per
  electrical half-cycle.
*/
`timescale 1ns/10ps
`default_nettype none

module auto_torque_control_regs #(
  parameter int LEARN_SWITCHES = 4  // Level changes per learning run
) (
  input  wire logic        clock_i,              // 200 MHz clock
  input  wire logic        rst_i,                // Asynchronous reset, active high
  input  wire logic [7:0]  reg_addr_i,           // Register address
  input  wire logic        reg_wr_i,             // Write strobe
  input  wire logic [7:0]  reg_wdata_i,          // Write data
  input  wire logic        reg_rd_i,             // Read strobe
  output logic      [7:0]  reg_rdata_o,          // Read data, valid after rd
  input  wire logic        half_cycle_i,         // Half-cycle pulse
  input  wire logic [15:0] load_error_i,         // Signed load error
  input  wire logic        supply_change_i,      // Supply change pulse
  input  wire logic [4:0]  learn_base_current_i, // Initial learn level / 8
  input  wire logic [7:0]  proportional_gain_i,  // Proportional gain
  input  wire logic [3:0]  derivative_gain_i,    // Derivative gain
  output logic      [7:0]  coil_current_o,       // Commanded coil current
  output logic             learning_o,           // Learning in progress
  output logic             learn_rescale_o       // Learning restarted pulse
);

  typedef enum {LEARN_IDLE, LEARN_BASE, LEARN_FINAL} learn_state_t;

  logic [7:0]   loop_control_q;
  logic [7:0]   coil_current_floor_q;
  logic [7:0]   coil_current_ceiling_q;
  logic [7:0]   derivative_gate_threshold_q;
  logic [7:0]   reserved_loop_tuning_q;
  logic [7:0]   learning_configuration_q;
  logic [7:0]   supply_rescale_control_q;
  logic [7:0]   reserved_trailing_q;
  logic [7:0]   live_current_value_q;
  logic [7:0]   live_current_value_d;
  logic [7:0]   reg_rdata_q;
  logic [7:0]   read_mux;
  logic         rescale_pulse_q;

  learn_state_t learn_state_q;
  learn_state_t learn_state_d;
  logic [5:0]   dwell_count_q;
  logic [7:0]   switch_count_q;
  logic         learn_done;
  logic         rescale_hit;
  logic [5:0]   dwell_target;
  logic [7:0]   learn_base_level;
  logic [9:0]   learn_final_sum;

  logic         load_adapt_enable;
  logic         learn_trigger;
  logic         supply_rescale_bit;

  pd_link_if    pd_link ();

  function automatic logic [7:0] clamp_current(input logic signed [9:0] value,
                                               input logic        [7:0] floor_v,
                                               input logic        [7:0] ceil_v);
    logic [7:0] result;
    result = value[7:0];
    if (value > signed'({2'b00, ceil_v}))
      result = ceil_v;
    else if (value < signed'({2'b00, floor_v}))
      result = floor_v;
    if (result > ceil_v)
      result = ceil_v;
    return result;
  endfunction

  function automatic logic [7:0] learn_increment(input logic [1:0] code);
    logic [7:0] inc;
    case (code)
      2'h0:    inc = auto_torque_pkg::INC_CODE0;
      2'h1:    inc = auto_torque_pkg::INC_CODE1;
      2'h2:    inc = auto_torque_pkg::INC_CODE2;
      default: inc = auto_torque_pkg::INC_CODE3;
    endcase
    return inc;
  endfunction

  assign load_adapt_enable  = loop_control_q[auto_torque_pkg::BIT_ENABLE];
  assign learn_trigger      = loop_control_q[auto_torque_pkg::BIT_LEARN_TRIGGER];
  assign supply_rescale_bit = supply_rescale_control_q[auto_torque_pkg::BIT_RESCALE];

  // PD correction unit
  assign pd_link.error     = load_error_i;
  assign pd_link.strobe    = half_cycle_i & load_adapt_enable;
  assign pd_link.lsb_drop  = learning_configuration_q[auto_torque_pkg::DROP_MSB:
                                                      auto_torque_pkg::DROP_LSB];
  assign pd_link.threshold = derivative_gate_threshold_q;
  assign pd_link.p_gain    = proportional_gain_i;
  assign pd_link.d_gain    = derivative_gain_i;

  pd_correction u_pd (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .link    (pd_link.calc)
  );

  // Learning levels and dwell
  always_comb
  begin
    dwell_target     = 6'((7'(learning_configuration_q[auto_torque_pkg::DWELL_MSB:
                          auto_torque_pkg::DWELL_LSB]) + 7'h01)
                          * 7'(auto_torque_pkg::DWELL_UNIT));
    learn_base_level = {learn_base_current_i, 3'h0};
    learn_final_sum  = {2'b00, learn_base_level}
                     + {2'b00, learn_increment(learning_configuration_q[
                        auto_torque_pkg::INC_MSB:auto_torque_pkg::INC_LSB])};
  end

  assign rescale_hit = supply_rescale_bit & supply_change_i
                     & (learn_state_q != LEARN_IDLE);
  assign learn_done  = (learn_state_q != LEARN_IDLE) & half_cycle_i & ~rescale_hit
                     & (dwell_count_q == dwell_target - 6'h01)
                     & (switch_count_q == 8'(LEARN_SWITCHES));

  always_comb
  begin
    learn_state_d = learn_state_q;
    case (learn_state_q)
      LEARN_IDLE:
      begin
        if (learn_trigger && load_adapt_enable)
          learn_state_d = LEARN_BASE;
      end
      LEARN_BASE, LEARN_FINAL:
      begin
        if (!load_adapt_enable || learn_done)
          learn_state_d = LEARN_IDLE;
        else if (rescale_hit)
          learn_state_d = LEARN_BASE;
        else if (half_cycle_i && dwell_count_q == dwell_target - 6'h01)
          learn_state_d = (learn_state_q == LEARN_BASE) ? LEARN_FINAL : LEARN_BASE;
      end
      default:
        learn_state_d = LEARN_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      learn_state_q   <= LEARN_IDLE;
      dwell_count_q   <= '0;
      switch_count_q  <= '0;
      rescale_pulse_q <= 1'b0;
    end
    else
    begin
      learn_state_q   <= learn_state_d;
      rescale_pulse_q <= rescale_hit;
      if (learn_state_q == LEARN_IDLE || rescale_hit)
      begin
        dwell_count_q  <= '0;
        switch_count_q <= '0;
      end
      else if (half_cycle_i)
      begin
        if (dwell_count_q == dwell_target - 6'h01)
        begin
          dwell_count_q  <= '0;
          switch_count_q <= switch_count_q + 8'h01;
        end
        else
          dwell_count_q <= dwell_count_q + 6'h01;
      end
    end
  end

  // Commanded current
  always_comb
  begin
    live_current_value_d = live_current_value_q;
    case (learn_state_q)
      LEARN_BASE:
        live_current_value_d = clamp_current(signed'({2'b00, learn_base_level}),
                                             coil_current_floor_q,
                                             coil_current_ceiling_q);
      LEARN_FINAL:
        live_current_value_d = clamp_current(signed'(learn_final_sum),
                                             coil_current_floor_q,
                                             coil_current_ceiling_q);
      default:
      begin
        if (!load_adapt_enable)
          live_current_value_d = coil_current_ceiling_q;
        else if (pd_link.corr_valid)
          live_current_value_d = clamp_current(
                                   signed'({2'b00, live_current_value_q})
                                   + pd_link.correction,
                                   coil_current_floor_q,
                                   coil_current_ceiling_q);
        else
          live_current_value_d = clamp_current(signed'({2'b00, live_current_value_q}),
                                               coil_current_floor_q,
                                               coil_current_ceiling_q);
      end
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      live_current_value_q <= auto_torque_pkg::RST_LIVE_CURRENT;
    else
      live_current_value_q <= live_current_value_d;
  end

  // Register writes
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      loop_control_q              <= auto_torque_pkg::RST_LOOP_CONTROL;
      coil_current_floor_q        <= auto_torque_pkg::RST_CURRENT_FLOOR;
      coil_current_ceiling_q      <= auto_torque_pkg::RST_CEILING;
      derivative_gate_threshold_q <= auto_torque_pkg::RST_DERIV_THR;
      reserved_loop_tuning_q      <= auto_torque_pkg::RST_RSVD_TUNING;
      learning_configuration_q    <= auto_torque_pkg::RST_LEARN_CFG;
      supply_rescale_control_q    <= auto_torque_pkg::RST_RESCALE_CTRL;
      reserved_trailing_q         <= auto_torque_pkg::RST_RSVD_TRAIL;
    end
    else
    begin
      if (learn_done)
        loop_control_q[auto_torque_pkg::BIT_LEARN_TRIGGER] <= 1'b0;
      if (reg_wr_i)
      begin
        case (reg_addr_i)
          auto_torque_pkg::OFF_LOOP_CONTROL:  loop_control_q              <= reg_wdata_i;
          auto_torque_pkg::OFF_CURRENT_FLOOR: coil_current_floor_q        <= reg_wdata_i;
          auto_torque_pkg::OFF_CEILING:       coil_current_ceiling_q      <= reg_wdata_i;
          auto_torque_pkg::OFF_DERIV_THR:     derivative_gate_threshold_q <= reg_wdata_i;
          auto_torque_pkg::OFF_RSVD_TUNING:   reserved_loop_tuning_q      <= reg_wdata_i;
          auto_torque_pkg::OFF_LEARN_CFG:     learning_configuration_q    <= reg_wdata_i;
          auto_torque_pkg::OFF_RESCALE_CTRL:  supply_rescale_control_q    <= reg_wdata_i;
          auto_torque_pkg::OFF_RSVD_TRAIL:    reserved_trailing_q         <= reg_wdata_i;
          default:                            ;
        endcase
      end
    end
  end

  // Register reads
  always_comb
  begin
    case (reg_addr_i)
      auto_torque_pkg::OFF_LOOP_CONTROL:  read_mux = loop_control_q;
      auto_torque_pkg::OFF_CURRENT_FLOOR: read_mux = coil_current_floor_q;
      auto_torque_pkg::OFF_CEILING:       read_mux = coil_current_ceiling_q;
      auto_torque_pkg::OFF_DERIV_THR:     read_mux = derivative_gate_threshold_q;
      auto_torque_pkg::OFF_RSVD_TUNING:   read_mux = reserved_loop_tuning_q;
      auto_torque_pkg::OFF_LEARN_CFG:     read_mux = learning_configuration_q;
      auto_torque_pkg::OFF_LIVE_CURRENT:
        read_mux = load_adapt_enable ? live_current_value_q
                                     : coil_current_ceiling_q;
      auto_torque_pkg::OFF_RESCALE_CTRL:  read_mux = supply_rescale_control_q;
      auto_torque_pkg::OFF_RSVD_TRAIL:    read_mux = reserved_trailing_q;
      default:                            read_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      reg_rdata_q <= 8'h00;
    else if (reg_rd_i)
      reg_rdata_q <= read_mux;
  end

  assign reg_rdata_o     = reg_rdata_q;
  assign coil_current_o  = live_current_value_q;
  assign learning_o      = (learn_state_q != LEARN_IDLE);
  assign learn_rescale_o = rescale_pulse_q;

endmodule

`default_nettype wire

// ### logic/auto_torque_pkg.sv
/*
  Constants for the auto-torque register group: register offsets, field
  positions, reset values and learning encodings.
  Assumes an 8-bit register port with 8-bit addresses.
*/
package auto_torque_pkg;

  localparam int          REG_W             = 8;
  localparam int          ADDR_W            = 8;
  localparam int          ERR_W             = 16;
  localparam int          CORR_W            = 10;

  // Register offsets
  localparam logic [7:0]  OFF_LOOP_CONTROL  = 8'h28;
  localparam logic [7:0]  OFF_CURRENT_FLOOR = 8'h29;
  localparam logic [7:0]  OFF_CEILING       = 8'h2a;
  localparam logic [7:0]  OFF_DERIV_THR     = 8'h2b;
  localparam logic [7:0]  OFF_RSVD_TUNING   = 8'h2c;
  localparam logic [7:0]  OFF_LEARN_CFG     = 8'h2d;
  localparam logic [7:0]  OFF_LIVE_CURRENT  = 8'h2e;
  localparam logic [7:0]  OFF_RESCALE_CTRL  = 8'h2f;
  localparam logic [7:0]  OFF_RSVD_TRAIL    = 8'h30;

  // Reset values
  localparam logic [7:0]  RST_LOOP_CONTROL  = 8'h08;
  localparam logic [7:0]  RST_CURRENT_FLOOR = 8'h0a;
  localparam logic [7:0]  RST_CEILING       = 8'hff;
  localparam logic [7:0]  RST_DERIV_THR     = 8'h05;
  localparam logic [7:0]  RST_RSVD_TUNING   = 8'h0f;
  localparam logic [7:0]  RST_LEARN_CFG     = 8'h00;
  localparam logic [7:0]  RST_LIVE_CURRENT  = 8'hff;
  localparam logic [7:0]  RST_RESCALE_CTRL  = 8'h00;
  localparam logic [7:0]  RST_RSVD_TRAIL    = 8'h00;

  // Field positions
  localparam int          BIT_ENABLE        = 7;
  localparam int          BIT_LEARN_TRIGGER = 6;
  localparam int          BIT_RESCALE       = 6;
  localparam int          DROP_MSB          = 7;
  localparam int          DROP_LSB          = 4;
  localparam int          INC_MSB           = 3;
  localparam int          INC_LSB           = 2;
  localparam int          DWELL_MSB         = 1;
  localparam int          DWELL_LSB         = 0;

  // Learning encodings
  localparam logic [7:0]  INC_CODE0         = 8'h80;
  localparam logic [7:0]  INC_CODE1         = 8'h10;
  localparam logic [7:0]  INC_CODE2         = 8'h20;
  localparam logic [7:0]  INC_CODE3         = 8'h40;
  localparam logic [5:0]  DWELL_UNIT        = 6'h08;
  localparam int          BASE_SHIFT        = 3;
  localparam int          CORR_SHIFT        = 8;

endpackage

// ### logic/pd_link_if.sv
/*
  Carrier between the register bank and its PD correction unit.
  Assumes both ends share clock_i.
*/
`timescale 1ns/10ps
`default_nettype none

interface pd_link_if;
  logic signed [15:0] error;       // Raw load error sample
  logic               strobe;      // One pulse per electrical half-cycle while load adaptation is enabled
  logic        [3:0]  lsb_drop;    // Error bits discarded
  logic        [7:0]  threshold;   // Derivative gate threshold
  logic        [7:0]  p_gain;      // Proportional gain
  logic        [3:0]  d_gain;      // Derivative gain
  logic signed [9:0]  correction;  // Scaled, saturated correction
  logic               corr_valid;  // Correction updated this cycle

  modport loop (output error, strobe, lsb_drop, threshold, p_gain, d_gain,
                input correction, corr_valid);
  modport calc (input error, strobe, lsb_drop, threshold, p_gain, d_gain,
                output correction, corr_valid);
endinterface

`default_nettype wire

// ### logic/pd_correction.sv
/*
  PD correction unit: truncates the error, gates the derivative term by
  threshold and produces a saturated correction per half-cycle strobe.
  Assumes gains and settings are static between strobes.
*/
`timescale 1ns/10ps
`default_nettype none

module pd_correction (
  input  wire logic clock_i,  // 200 MHz clock
  input  wire logic rst_i,    // Asynchronous reset, active high
  pd_link_if.calc   link      // Error in, correction out
);

  logic signed [15:0] err_trunc;
  logic signed [15:0] prev_err_q;
  logic signed [16:0] delta;
  logic        [16:0] delta_mag;
  logic signed [25:0] p_term;
  logic signed [25:0] d_term;
  logic signed [25:0] sum;
  logic signed [25:0] scaled;
  logic signed [9:0]  sat;
  logic signed [9:0]  correction_q;
  logic               valid_q;

  always_comb
  begin
    err_trunc = link.error >>> link.lsb_drop;
    delta     = 17'(err_trunc) - 17'(prev_err_q);
    delta_mag = delta[16] ? 17'(-delta) : delta;
    p_term    = 26'(err_trunc) * 26'(signed'({1'b0, link.p_gain}));
    if (delta_mag > 17'(link.threshold))
      d_term = 26'(delta) * 26'(signed'({1'b0, link.d_gain}));
    else
      d_term = '0;
    sum    = p_term + d_term;
    scaled = sum >>> auto_torque_pkg::CORR_SHIFT;
    if (scaled > 26'sd255)
      sat = 10'sd255;
    else if (scaled < -26'sd255)
      sat = -10'sd255;
    else
      sat = scaled[9:0];
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      prev_err_q   <= '0;
      correction_q <= '0;
      valid_q      <= 1'b0;
    end
    else
    begin
      valid_q <= link.strobe;
      if (link.strobe)
      begin
        prev_err_q   <= err_trunc;
        correction_q <= sat;
      end
    end
  end

  assign link.correction = correction_q;
  assign link.corr_valid = valid_q;

endmodule

`default_nettype wire

// ### verif/auto_torque_control_regs_asserts.sv
/*
  Checker for the auto-torque register bank: mirrors the written limits
  and watches the commanded current and the register port.
  Assumes it is bound to auto_torque_control_regs, one clock domain.
*/
`timescale 1ns/10ps
`default_nettype none

module auto_torque_control_regs_chk #(
  parameter int LEARN_SWITCHES = 4  // Level changes per run
) (
  input wire logic        clock_i,              // Clock
  input wire logic        rst_i,                // Reset
  input wire logic [7:0]  reg_addr_i,           // Address
  input wire logic        reg_wr_i,             // Write strobe
  input wire logic [7:0]  reg_wdata_i,          // Write data
  input wire logic        reg_rd_i,             // Read strobe
  input wire logic [7:0]  reg_rdata_o,          // Read data
  input wire logic        half_cycle_i,         // Half-cycle pulse
  input wire logic [15:0] load_error_i,         // Load error
  input wire logic        supply_change_i,      // Supply change
  input wire logic [4:0]  learn_base_current_i, // Base level / 8
  input wire logic [7:0]  proportional_gain_i,  // P gain
  input wire logic [3:0]  derivative_gain_i,    // D gain
  input wire logic [7:0]  coil_current_o,       // Current
  input wire logic        learning_o,           // Learning
  input wire logic        learn_rescale_o       // Rescale pulse
);
  logic [7:0] ceil_q;
  logic [7:0] floor_q;
  logic       en_q;
  logic       scale_q;

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ceil_q  <= 8'hff;
      floor_q <= 8'h0a;
      en_q    <= 1'b0;
      scale_q <= 1'b0;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == 8'h2a) ceil_q <= reg_wdata_i;
      if (reg_addr_i == 8'h29) floor_q <= reg_wdata_i;
      if (reg_addr_i == 8'h28) en_q <= reg_wdata_i[7];
      if (reg_addr_i == 8'h2f) scale_q <= reg_wdata_i[6];
    end
  end

  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);

  property p_ceiling_bound;
    ceil_q == $past(ceil_q, 2) |-> coil_current_o <= ceil_q;
  endproperty
  a_ceiling_bound: assert property (p_ceiling_bound) else $error("coil above ceiling");

  property p_floor_bound;
    floor_q <= ceil_q && floor_q == $past(floor_q, 2) && ceil_q == $past(ceil_q, 2)
      |-> coil_current_o >= floor_q;
  endproperty
  a_floor_bound: assert property (p_floor_bound) else $error("coil below floor");

  property p_off_tracks;
    !en_q && !$past(en_q, 2) && ceil_q == $past(ceil_q, 2) |-> coil_current_o == ceil_q;
  endproperty
  a_off_tracks: assert property (p_off_tracks) else $error("coil not at ceiling");

  property p_rd_ceiling;
    reg_rd_i && reg_addr_i == 8'h2a |=> reg_rdata_o == $past(ceil_q);
  endproperty
  a_rd_ceiling: assert property (p_rd_ceiling) else $error("ceiling readback");

  property p_rd_live_off;
    reg_rd_i && reg_addr_i == 8'h2e && !en_q && !$past(en_q, 2)
      && ceil_q == $past(ceil_q, 2) |=> reg_rdata_o == $past(ceil_q);
  endproperty
  a_rd_live_off: assert property (p_rd_live_off) else $error("live read off");

  property p_rd_live_on;
    reg_rd_i && reg_addr_i == 8'h2e && en_q && $past(en_q)
      |=> reg_rdata_o == $past(coil_current_o);
  endproperty
  a_rd_live_on: assert property (p_rd_live_on) else $error("live read on");

  property p_live_wr;
    reg_wr_i && reg_addr_i == 8'h2e && en_q && !learning_o && !half_cycle_i
      && !$past(half_cycle_i) && !$past(half_cycle_i, 2)
      |=> $stable(coil_current_o) ##1 $stable(coil_current_o);
  endproperty
  a_live_wr: assert property (p_live_wr) else $error("live write disturbed");

  property p_idle_off;
    !en_q && !$past(en_q) && !$past(en_q, 2) |-> !learning_o;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("learning while off");

  property p_learn_go;
    reg_wr_i && reg_addr_i == 8'h28 && reg_wdata_i[7:6] == 2'b11 && !learning_o
      |-> ##2 learning_o;
  endproperty
  a_learn_go: assert property (p_learn_go) else $error("learning not started");

  property p_rescale;
    learn_rescale_o |-> scale_q && ($past(supply_change_i) || $past(supply_change_i, 2));
  endproperty
  a_rescale: assert property (p_rescale) else $error("stray rescale");
endmodule

bind auto_torque_control_regs auto_torque_control_regs_chk #(
  .LEARN_SWITCHES(LEARN_SWITCHES)
) chk_u (
  .clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .half_cycle_i(half_cycle_i), .load_error_i(load_error_i),
  .supply_change_i(supply_change_i), .learn_base_current_i(learn_base_current_i),
  .proportional_gain_i(proportional_gain_i), .derivative_gain_i(derivative_gain_i),
  .coil_current_o(coil_current_o), .learning_o(learning_o),
  .learn_rescale_o(learn_rescale_o)
);

`default_nettype wire

// ### verif/auto_torque_control_regs_tb.sv
/*
  Self-checking bench for the auto-torque register bank.
  Assumes the checker file is compiled alongside and binds itself.
*/
`timescale 1ns/10ps
`default_nettype none

module auto_torque_control_regs_tb;
  logic        clock_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic        wr = 1'b0;
  logic [7:0]  wdata = 8'h00;
  logic        rd = 1'b0;
  logic [7:0]  rdata;
  logic        half = 1'b0;
  logic [15:0] err = 16'h0000;
  logic        supply = 1'b0;
  logic [4:0]  base = 5'h00;
  logic [7:0]  kp = 8'h00;
  logic [3:0]  kd = 4'h0;
  logic [7:0]  coil;
  logic        lrn;
  logic        resc;
  logic [7:0]  got;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          k;

  always #2.5 clock_i = ~clock_i;

  auto_torque_control_regs #(.LEARN_SWITCHES(1)) dut_u (
    .clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata), .half_cycle_i(half),
    .load_error_i(err), .supply_change_i(supply), .learn_base_current_i(base),
    .proportional_gain_i(kp), .derivative_gain_i(kd), .coil_current_o(coil),
    .learning_o(lrn), .learn_rescale_o(resc)
  );

  task automatic chk(input logic [7:0] exp, input logic [7:0] act);
    num_checks++;
    if (act !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, act);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock_i);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a);
    @(posedge clock_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_i);
    rd <= 1'b0;
    @(negedge clock_i);
    got = rdata;
  endtask

  // Half-cycle pulses two cycles apart, then time for the current to settle
  task automatic pulses(input int n);
    repeat (n)
    begin
      @(posedge clock_i);
      half <= 1'b1;
      @(posedge clock_i);
      half <= 1'b0;
    end
    repeat (3) @(posedge clock_i);
    @(negedge clock_i);
  endtask

  task automatic strobe(input logic [15:0] e, input logic [7:0] p, input logic [3:0] d,
                        input logic [7:0] exp);
    @(posedge clock_i);
    err <= e;
    kp <= p;
    kd <= d;
    pulses(1);
    chk(exp, coil);
  endtask

  task automatic supply_pulse(input logic [7:0] exp);
    int seen;
    seen = 0;
    @(posedge clock_i);
    supply <= 1'b1;
    @(posedge clock_i);
    supply <= 1'b0;
    repeat (4)
    begin
      @(negedge clock_i);
      seen += int'(resc === 1'b1);
    end
    chk(exp, 8'(seen));
  endtask

  task automatic test_reset;
    logic [7:0] tab [9];
    tab = '{8'h08, 8'h0a, 8'hff, 8'h05, 8'h0f, 8'h00, 8'hff, 8'h00, 8'h00};
    for (k = 0; k < 9; k++)
    begin
      rreg(8'h28 + 8'(k));
      chk(tab[k], got);
    end
    rreg(8'h40);
    chk(8'h00, got);
    $display("test_reset done");
  endtask

  task automatic test_regs;
    wreg(8'h2a, 8'h80);
    rreg(8'h2a);
    chk(8'h80, got);
    wreg(8'h2e, 8'h12);
    rreg(8'h2e);
    chk(8'h80, got);
    chk(8'h80, coil);
    wreg(8'h2d, 8'h5a);
    rreg(8'h2d);
    chk(8'h5a, got);
    wreg(8'h2f, 8'h40);
    rreg(8'h2f);
    chk(8'h40, got);
    wreg(8'h2f, 8'h00);
    $display("test_regs done");
  endtask

  task automatic test_loop;
    wreg(8'h29, 8'h20);
    wreg(8'h2a, 8'hc0);
    wreg(8'h2b, 8'h40);
    wreg(8'h2d, 8'h40);
    wreg(8'h28, 8'h88);
    strobe(16'hf000, 8'hff, 4'h0, 8'h20);
    strobe(16'hf000, 8'h00, 4'hf, 8'h20);
    strobe(16'hf400, 8'h00, 4'hf, 8'h20);
    strobe(16'hfc00, 8'h00, 4'hf, 8'h27);
    rreg(8'h2e);
    chk(8'h27, got);
    wreg(8'h2e, 8'h99);
    rreg(8'h2e);
    chk(8'h27, got);
    strobe(16'h7000, 8'hff, 4'h0, 8'hc0);
    wreg(8'h28, 8'h08);
    strobe(16'h8000, 8'hff, 4'h0, 8'hc0);
    $display("test_loop done");
  endtask

  task automatic test_learn;
    logic [7:0] inc [4];
    inc = '{8'd128, 8'd16, 8'd32, 8'd64};
    @(posedge clock_i);
    kp <= 8'h00;
    base <= 5'd8;
    wreg(8'h2a, 8'hff);
    wreg(8'h29, 8'h0a);
    for (k = 0; k < 4; k++)
    begin
      wreg(8'h2d, {4'h0, 2'(k), 2'(k)});
      wreg(8'h28, 8'hc8);
      pulses(0);
      chk(8'h01, {7'h0, lrn});
      chk(8'h40, coil);
      pulses(8 * (k + 1) - 1);
      chk(8'h40, coil);
      pulses(1);
      chk(8'h40 + inc[k], coil);
      pulses(8 * (k + 1));
      chk(8'h00, {7'h0, lrn});
      rreg(8'h28);
      chk(8'h88, got);
    end
    $display("test_learn done");
  endtask

  task automatic test_rescale;
    wreg(8'h2d, 8'h03);
    wreg(8'h28, 8'hc8);
    pulses(4);
    supply_pulse(8'h00);
    wreg(8'h2f, 8'h40);
    supply_pulse(8'h01);
    pulses(31);
    chk(8'h40, coil);
    pulses(1);
    chk(8'hc0, coil);
    wreg(8'h28, 8'h08);
    pulses(0);
    chk(8'h00, {7'h0, lrn});
    wreg(8'h2f, 8'h00);
    $display("test_rescale done");
  endtask

  task automatic close_out;
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    repeat (12) @(posedge clock_i);
    rst_i <= 1'b0;
    test_reset;
    test_regs;
    test_loop;
    test_learn;
    test_rescale;
    close_out;
  end

  initial
  begin
    #100000;
    n_mismatch++;
    close_out;
  end
endmodule

`default_nettype wire
